// ---- logic/llc_xhdr_pkg.sv ----
// constants, carrier structs and crc helpers for the extended llc header framer
// assumes one 125 mhz system clock and a synchronous active-high reset
package llc_xhdr_pkg;

	// ************************************************************
	// lengths and header layout
	// ************************************************************
	localparam logic [10:0] LEN_MIN = 11'h02e; // shortest valid length field
	localparam logic [10:0] LEN_MAX = 11'h5dc; // longest valid length field
	localparam logic [10:0] UI_OVERHEAD = 11'h00c; // 4 hdr + 4 stamp + 4 crc bytes
	localparam logic [10:0] TEST_OVERHEAD = 11'h004; // 4 hdr bytes, rest zero fill
	localparam logic [10:0] HDR_LAST_IDX = 11'h005; // len hi, len lo, dsap, ssap, ctrl, ext
	localparam logic [10:0] WORD_LAST_IDX = 11'h003; // stamp word and crc word bytes

	// ************************************************************
	// field values
	// ************************************************************
	localparam logic [7:0] SAP_TEST = 8'h01; // both saps of a test pdu
	localparam logic [7:0] CTRL_UI = 8'h03; // ui, poll bit 0
	localparam logic [7:0] CTRL_TEST = 8'he3; // test, poll/final bit 0
	localparam logic [7:0] HOP_MAX = 8'h3f; // largest origin hop budget
	localparam logic [7:0] HOP_ECHO = 8'hc0; // hop value of an echoed test pdu
	localparam logic [7:0] SEQ_RESET = 8'h00; // first sequence after reset
	localparam logic [7:0] SEQ_FIRST = 8'h01; // wrap target
	localparam logic [7:0] SEQ_LAST = 8'hff; // wrap point

	// ************************************************************
	// crc polynomials, explicit form (top bit implied)
	// ************************************************************
	localparam logic [11:0] CRC12_POLY = 12'h1f1; // x12+x8+x7+x6+x5+x4+1
	localparam logic [31:0] CRC32_POLY = 32'h741b8cd7; // same polynomial as 0xba0dc66b
	localparam logic [31:0] CRC32_INIT = 32'h00000000; // zero start, no final invert

	// ************************************************************
	// sizes
	// ************************************************************
	localparam int SEQ_ADDR_W = 14; // 7 dsap bits by 7 ssap bits
	localparam int SEQ_DEPTH = 16384; // one counter per sap pair
	localparam logic [13:0] SEQ_ADDR_LAST = 14'h3fff; // end of reset sweep
	localparam int FIFO_W = 8; // payload byte
	localparam int FIFO_DEPTH = 8; // payload words buffered

	// ************************************************************
	// carriers
	// ************************************************************
	typedef struct packed {
		logic is_test; // 1 test pdu, 0 ui pdu
		logic [7:0] dsap; // destination sap
		logic [7:0] ssap; // source sap
		logic [7:0] hop; // route_hop_budget at origin, test only
		logic [10:0] len; // length field value
	} tx_req_s;

	typedef struct packed {
		logic is_test; // header was a test pdu
		logic [7:0] dsap; // received dsap
		logic [7:0] ssap; // received ssap
		logic [7:0] ext; // channel_sequence_count or route_hop_budget
		logic [7:0] fwd_hop; // hop budget a relay would pass on
		logic [19:0] stamp; // ui time-stamp
	} rx_info_s;

	// ************************************************************
	// helpers
	// ************************************************************
	// header crc over 52 bits, msb first
	function automatic logic [11:0] crc12_calc(input logic [51:0] bits);
		logic [11:0] c;
		logic fb;
		c = 12'h000;
		for (int i = 51; i >= 0; i--) begin
			fb = c[11] ^ bits[i];
			c = {c[10:0], 1'b0};
			if (fb) begin
				c = c ^ CRC12_POLY;
			end
		end
		return c;
	endfunction

	// payload crc, one byte msb first
	function automatic logic [31:0] crc32_byte(input logic [31:0] crc, input logic [7:0] d);
		logic [31:0] c;
		logic fb;
		c = crc;
		for (int i = 7; i >= 0; i--) begin
			fb = c[31] ^ d[i];
			c = {c[30:0], 1'b0};
			if (fb) begin
				c = c ^ CRC32_POLY;
			end
		end
		return c;
	endfunction

	// length window check
	function automatic logic len_ok(input logic [10:0] len);
		return (len >= LEN_MIN) && (len <= LEN_MAX);
	endfunction

endpackage

// ---- logic/byte_fifo.sv ----
// small synchronous fifo with valid/ready on both sides
// assumes one clock, synchronous active-high reset, depth a power of two
`timescale 1ns/1ps
module byte_fifo #(
	parameter int W = 8,
	parameter int D = 8
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [W-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [W-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(D);

	logic [W-1:0] mem [D]; // storage
	logic [AW-1:0] wr_ptr_r, wr_ptr_nxt; // write pointer
	logic [AW-1:0] rd_ptr_r, rd_ptr_nxt; // read pointer
	logic [AW:0] count_r, count_nxt; // words held
	logic room_r, room_nxt; // registered not-full, in_ready straight from a flop
	logic push, pop;

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		push = in_valid && room_r;
		pop = out_ready && (count_r != '0);
		wr_ptr_nxt = push ? AW'(wr_ptr_r + 1'b1) : wr_ptr_r;
		rd_ptr_nxt = pop ? AW'(rd_ptr_r + 1'b1) : rd_ptr_r;
		count_nxt = count_r;
		if (push && !pop) begin
			count_nxt = (AW+1)'(count_r + 1'b1);
		end else if (pop && !push) begin
			count_nxt = (AW+1)'(count_r - 1'b1);
		end
		room_nxt = (count_nxt != (AW+1)'(D));
	end

	// ************************************************************
	// registers
	// ************************************************************
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
			room_r <= 1'b1;
		end else begin
			wr_ptr_r <= wr_ptr_nxt;
			rd_ptr_r <= rd_ptr_nxt;
			count_r <= count_nxt;
			room_r <= room_nxt;
		end
	end

	// storage needs no reset
	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem[wr_ptr_r] <= in_data;
		end
	end

	assign in_ready = room_r;
	assign out_valid = (count_r != '0);
	assign out_data = mem[rd_ptr_r];
endmodule

// ---- logic/llc_extended_header_framer.sv ----
// extended llc header framer: builds ui/test pdus toward the mac, checks received ones
// assumes a mac that adds addresses and fcs, and a byte stream framed by a last flag
//
// Function
// - length field valid only 46 through 1500
// - emitted ui sap numbers always have bit zero clear
// - test pdus use sap 1 both ways
// - ui control field keeps poll bit zero
// - test control field keeps poll/final zero
// - ui sequence octet follows control field
// - separate sequence counter per sap pair
// - sequence 1..255 wraps, 0 first after reset
// - test hop octet follows control field
// - origin hop budget never above 63
// - each relay lowers hop budget by one
// - arriving test hop nonzero flags an error
// - zero-hop test echoed back with hop 0xc0
// - extended header is 32 bits long
// - ui adds second 32-bit header word
// - upper 20 bits: microseconds, or seconds when sequence 0
// - lower 12 bits: header crc, receiver checks
// - ui data covered by separate 32-bit crc
`timescale 1ns/1ps
module llc_extended_header_framer
	import llc_xhdr_pkg::*;
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire tx_req_s tx_req,
	input wire logic tx_req_valid,
	output logic tx_req_ready,
	output logic tx_req_err,
	input wire logic [7:0] pay_data,
	input wire logic pay_valid,
	output logic pay_ready,
	input wire logic [19:0] usec_in_sec,
	input wire logic [19:0] sec_of_day,
	output logic [7:0] mac_tx_data,
	output logic mac_tx_valid,
	output logic mac_tx_last,
	input wire logic mac_tx_ready,
	input wire logic [7:0] mac_rx_data,
	input wire logic mac_rx_valid,
	input wire logic mac_rx_last,
	output rx_info_s rx_info,
	output logic [7:0] rx_data,
	output logic rx_data_valid,
	output logic rx_frame_ok,
	output logic rx_frame_err,
	output logic rx_hop_err
);
	typedef enum logic [5:0] {
		TX_INIT = 6'h01, TX_IDLE = 6'h02, TX_HDR = 6'h04,
		TX_STAMP = 6'h08, TX_BODY = 6'h10, TX_TAIL = 6'h20
	} tx_state_e;
	typedef enum logic [4:0] {
		RX_HDR = 5'h01, RX_STAMP = 5'h02, RX_BODY = 5'h04, RX_TAIL = 5'h08, RX_SKIP = 5'h10
	} rx_state_e;

	// ************************************************************
	// payload buffer
	// ************************************************************
	logic [7:0] fifo_data; // head byte
	logic fifo_valid; // head present
	logic fifo_pop; // body stage takes head

	byte_fifo #(.W(FIFO_W), .D(FIFO_DEPTH)) u_pay_fifo (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.in_data(pay_data),
		.in_valid(pay_valid),
		.in_ready(pay_ready),
		.out_data(fifo_data),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop)
	);

	// ************************************************************
	// transmit state
	// ************************************************************
	tx_state_e tx_state_r, tx_state_nxt;
	tx_req_s tx_cur_r, tx_cur_nxt; // pdu being sent
	logic [10:0] tx_idx_r, tx_idx_nxt; // byte index inside a section
	logic [10:0] tx_left_r, tx_left_nxt; // body bytes still to send
	logic [7:0] tx_ext_r, tx_ext_nxt; // sequence or hop octet
	logic [31:0] tx_word_r, tx_word_nxt; // stamp + header crc word
	logic [31:0] tx_crc_r, tx_crc_nxt; // running payload crc
	logic [7:0] mac_tx_data_r, mac_tx_data_nxt;
	logic mac_tx_valid_r, mac_tx_valid_nxt;
	logic mac_tx_last_r, mac_tx_last_nxt;
	logic tx_req_ready_r, tx_req_ready_nxt;
	logic tx_req_err_r, tx_req_err_nxt;
	logic [13:0] init_addr_r, init_addr_nxt; // reset sweep address
	logic echo_pend_r, echo_pend_nxt; // test echo waiting to go out
	logic [10:0] echo_len_r, echo_len_nxt; // length of pdu to echo
	logic echo_set, echo_take; // rx raises, tx consumes
	logic [10:0] echo_set_len;

	logic [7:0] seq_mem [SEQ_DEPTH]; // next sequence per sap pair
	logic seq_we;
	logic [SEQ_ADDR_W-1:0] seq_addr;
	logic [7:0] seq_wdata;
	logic [7:0] seq_cur; // value due for this pair
	logic [19:0] stamp;
	logic adv; // output register may load
	logic [7:0] d_sap, s_sap;

	// ************************************************************
	// transmit next-state
	// ************************************************************
	always_comb begin
		tx_state_nxt = tx_state_r;
		tx_cur_nxt = tx_cur_r;
		tx_idx_nxt = tx_idx_r;
		tx_left_nxt = tx_left_r;
		tx_ext_nxt = tx_ext_r;
		tx_word_nxt = tx_word_r;
		tx_crc_nxt = tx_crc_r;
		init_addr_nxt = init_addr_r;
		tx_req_err_nxt = 1'b0;
		echo_take = 1'b0;
		fifo_pop = 1'b0;
		seq_we = 1'b0;
		d_sap = tx_req.dsap & 8'hfe;
		s_sap = tx_req.ssap & 8'hfe;
		seq_addr = {d_sap[7:1], s_sap[7:1]};
		seq_cur = seq_mem[seq_addr];
		seq_wdata = (seq_cur == SEQ_LAST) ? SEQ_FIRST : 8'(seq_cur + 8'h01);
		stamp = (seq_cur == SEQ_RESET) ? sec_of_day : usec_in_sec;
		adv = !mac_tx_valid_r || mac_tx_ready;
		mac_tx_data_nxt = mac_tx_data_r;
		mac_tx_valid_nxt = adv ? 1'b0 : mac_tx_valid_r;
		mac_tx_last_nxt = adv ? 1'b0 : mac_tx_last_r;
		case (tx_state_r)
			TX_INIT: begin
				// every pair starts at sequence 0; tx held off meanwhile
				seq_we = 1'b1;
				seq_addr = init_addr_r;
				seq_wdata = SEQ_RESET;
				init_addr_nxt = 14'(init_addr_r + 14'h0001);
				if (init_addr_r == SEQ_ADDR_LAST) begin
					tx_state_nxt = TX_IDLE;
				end
			end
			TX_IDLE: begin
				tx_idx_nxt = 11'h000;
				tx_crc_nxt = CRC32_INIT;
				if (tx_req_valid && tx_req_ready_r) begin
					if (!len_ok(tx_req.len) || (tx_req.is_test && tx_req.hop > HOP_MAX)) begin
						tx_req_err_nxt = 1'b1;
					end else if (tx_req.is_test) begin
						tx_cur_nxt = {1'b1, SAP_TEST, SAP_TEST, tx_req.hop, tx_req.len};
						tx_ext_nxt = tx_req.hop;
						tx_left_nxt = 11'(tx_req.len - TEST_OVERHEAD);
						tx_state_nxt = TX_HDR;
					end else begin
						tx_cur_nxt = {1'b0, d_sap, s_sap, 8'h00, tx_req.len};
						tx_ext_nxt = seq_cur;
						seq_we = 1'b1;
						tx_word_nxt = {stamp, crc12_calc({d_sap, s_sap, CTRL_UI, seq_cur, stamp})};
						tx_left_nxt = 11'(tx_req.len - UI_OVERHEAD);
						tx_state_nxt = TX_HDR;
					end
				end else if (echo_pend_r) begin
					echo_take = 1'b1;
					tx_cur_nxt = {1'b1, SAP_TEST, SAP_TEST, HOP_ECHO, echo_len_r};
					tx_ext_nxt = HOP_ECHO;
					tx_left_nxt = 11'(echo_len_r - TEST_OVERHEAD);
					tx_state_nxt = TX_HDR;
				end
			end
			TX_HDR: if (adv) begin
				// length, then dsap, ssap, control, extension: the 32-bit llc header, 48 bits in all
				mac_tx_valid_nxt = 1'b1;
				tx_idx_nxt = 11'(tx_idx_r + 11'h001);
				case (tx_idx_r[2:0])
					3'h0: mac_tx_data_nxt = {5'h00, tx_cur_r.len[10:8]};
					3'h1: mac_tx_data_nxt = tx_cur_r.len[7:0];
					3'h2: mac_tx_data_nxt = tx_cur_r.dsap;
					3'h3: mac_tx_data_nxt = tx_cur_r.ssap;
					3'h4: mac_tx_data_nxt = tx_cur_r.is_test ? CTRL_TEST : CTRL_UI;
					default: mac_tx_data_nxt = tx_ext_r;
				endcase
				if (tx_idx_r == HDR_LAST_IDX) begin
					tx_idx_nxt = 11'h000;
					tx_state_nxt = tx_cur_r.is_test ? TX_BODY : TX_STAMP;
				end
			end
			TX_STAMP: if (adv) begin
				mac_tx_valid_nxt = 1'b1;
				mac_tx_data_nxt = tx_word_r[31:24];
				tx_word_nxt = {tx_word_r[23:0], 8'h00};
				tx_idx_nxt = 11'(tx_idx_r + 11'h001);
				if (tx_idx_r == WORD_LAST_IDX) begin
					tx_state_nxt = TX_BODY;
				end
			end
			TX_BODY: if (adv && (tx_cur_r.is_test || fifo_valid)) begin
				// test body is zero fill; ui body waits on the payload fifo
				mac_tx_valid_nxt = 1'b1;
				mac_tx_data_nxt = tx_cur_r.is_test ? 8'h00 : fifo_data;
				fifo_pop = !tx_cur_r.is_test;
				tx_crc_nxt = crc32_byte(tx_crc_r, fifo_data);
				tx_left_nxt = 11'(tx_left_r - 11'h001);
				if (tx_left_r == 11'h001) begin
					tx_idx_nxt = 11'h000;
					mac_tx_last_nxt = tx_cur_r.is_test;
					tx_state_nxt = tx_cur_r.is_test ? TX_IDLE : TX_TAIL;
				end
			end
			TX_TAIL: if (adv) begin
				mac_tx_valid_nxt = 1'b1;
				mac_tx_data_nxt = tx_crc_r[31:24];
				tx_crc_nxt = {tx_crc_r[23:0], 8'h00};
				tx_idx_nxt = 11'(tx_idx_r + 11'h001);
				if (tx_idx_r == WORD_LAST_IDX) begin
					mac_tx_last_nxt = 1'b1;
					tx_state_nxt = TX_IDLE;
				end
			end
			default: tx_state_nxt = TX_INIT;
		endcase
		// an echo raised now beats the take of an older one
		echo_pend_nxt = echo_set ? 1'b1 : (echo_take ? 1'b0 : echo_pend_r);
		echo_len_nxt = echo_set ? echo_set_len : echo_len_r;
		tx_req_ready_nxt = (tx_state_nxt == TX_IDLE) && !echo_pend_nxt;
	end

	// ************************************************************
	// transmit registers
	// ************************************************************
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			tx_state_r <= TX_INIT;
			tx_cur_r <= '0;
			tx_idx_r <= 11'h000;
			tx_left_r <= 11'h000;
			tx_ext_r <= 8'h00;
			tx_word_r <= 32'h00000000;
			tx_crc_r <= CRC32_INIT;
			mac_tx_data_r <= 8'h00;
			mac_tx_valid_r <= 1'b0;
			mac_tx_last_r <= 1'b0;
			tx_req_ready_r <= 1'b0;
			tx_req_err_r <= 1'b0;
			init_addr_r <= 14'h0000;
			echo_pend_r <= 1'b0;
			echo_len_r <= 11'h000;
		end else begin
			tx_state_r <= tx_state_nxt;
			tx_cur_r <= tx_cur_nxt;
			tx_idx_r <= tx_idx_nxt;
			tx_left_r <= tx_left_nxt;
			tx_ext_r <= tx_ext_nxt;
			tx_word_r <= tx_word_nxt;
			tx_crc_r <= tx_crc_nxt;
			mac_tx_data_r <= mac_tx_data_nxt;
			mac_tx_valid_r <= mac_tx_valid_nxt;
			mac_tx_last_r <= mac_tx_last_nxt;
			tx_req_ready_r <= tx_req_ready_nxt;
			tx_req_err_r <= tx_req_err_nxt;
			init_addr_r <= init_addr_nxt;
			echo_pend_r <= echo_pend_nxt;
			echo_len_r <= echo_len_nxt;
		end
	end

	// sequence table, cleared by the sweep rather than by reset
	always_ff @(posedge sys_clk) begin
		if (seq_we) begin
			seq_mem[seq_addr] <= seq_wdata;
		end
	end

	// ************************************************************
	// receive state
	// ************************************************************
	rx_state_e rx_state_r, rx_state_nxt;
	logic [10:0] rx_idx_r, rx_idx_nxt; // byte index inside a section
	logic [10:0] rx_left_r, rx_left_nxt; // body bytes still due
	logic [10:0] rx_len_r, rx_len_nxt; // received length field
	logic [31:0] rx_hdr_r, rx_hdr_nxt; // dsap, ssap, ctrl, ext
	logic [31:0] rx_word_r, rx_word_nxt; // stamp word, then crc word
	logic [31:0] rx_crc_r, rx_crc_nxt; // running payload crc
	rx_info_s rx_info_r, rx_info_nxt;
	logic [7:0] rx_data_r, rx_data_nxt;
	logic rx_data_valid_r, rx_data_valid_nxt;
	logic rx_ok_r, rx_ok_nxt;
	logic rx_err_r, rx_err_nxt;
	logic rx_hop_err_r, rx_hop_err_nxt;
	logic [31:0] rx_last_word; // word completed by this byte
	logic rx_is_test;

	// ************************************************************
	// receive next-state
	// ************************************************************
	always_comb begin
		rx_state_nxt = rx_state_r;
		rx_idx_nxt = rx_idx_r;
		rx_left_nxt = rx_left_r;
		rx_len_nxt = rx_len_r;
		rx_hdr_nxt = rx_hdr_r;
		rx_word_nxt = rx_word_r;
		rx_crc_nxt = rx_crc_r;
		rx_info_nxt = rx_info_r;
		rx_data_nxt = rx_data_r;
		rx_data_valid_nxt = 1'b0;
		rx_ok_nxt = 1'b0;
		rx_err_nxt = 1'b0;
		rx_hop_err_nxt = 1'b0;
		echo_set = 1'b0;
		echo_set_len = rx_len_r;
		rx_last_word = {rx_word_r[23:0], mac_rx_data};
		// at the ext byte dsap and ssap still sit one byte below the top
		rx_is_test = (rx_hdr_r[23:16] == SAP_TEST) && (rx_hdr_r[15:8] == SAP_TEST);
		if (mac_rx_valid) begin
			rx_idx_nxt = 11'(rx_idx_r + 11'h001);
			case (rx_state_r)
				RX_HDR: begin
					if (rx_idx_r < 11'h002) begin
						rx_len_nxt = {rx_len_r[2:0], mac_rx_data};
					end else begin
						rx_hdr_nxt = {rx_hdr_r[23:0], mac_rx_data};
					end
					if (rx_idx_r == HDR_LAST_IDX) begin
						rx_idx_nxt = 11'h000;
						rx_info_nxt = {rx_is_test, rx_hdr_r[23:8], mac_rx_data,
							8'(mac_rx_data - 8'h01), rx_info_r.stamp};
						rx_state_nxt = mac_rx_last ? RX_HDR : RX_SKIP;
						if (!len_ok(rx_len_r)) begin
							rx_err_nxt = 1'b1;
						end else if (rx_is_test && mac_rx_data != 8'h00) begin
							rx_hop_err_nxt = 1'b1;
						end else if (rx_is_test) begin
							echo_set = 1'b1;
						end else if (mac_rx_last) begin
							rx_err_nxt = 1'b1;
						end else begin
							rx_state_nxt = RX_STAMP;
						end
					end else if (mac_rx_last) begin
						rx_idx_nxt = 11'h000;
						rx_err_nxt = 1'b1;
					end
				end
				RX_STAMP: begin
					rx_word_nxt = rx_last_word;
					if (rx_idx_r == WORD_LAST_IDX) begin
						rx_idx_nxt = 11'h000;
						rx_left_nxt = 11'(rx_len_r - UI_OVERHEAD);
						rx_crc_nxt = CRC32_INIT;
						rx_info_nxt.stamp = rx_last_word[31:12];
						rx_state_nxt = RX_BODY;
						if (crc12_calc({rx_hdr_r, rx_last_word[31:12]}) != rx_last_word[11:0]) begin
							rx_err_nxt = 1'b1;
							rx_state_nxt = mac_rx_last ? RX_HDR : RX_SKIP;
						end else if (mac_rx_last) begin
							rx_err_nxt = 1'b1;
							rx_state_nxt = RX_HDR;
						end
					end else if (mac_rx_last) begin
						rx_idx_nxt = 11'h000;
						rx_err_nxt = 1'b1;
						rx_state_nxt = RX_HDR;
					end
				end
				RX_BODY: begin
					// data goes out as it arrives; the end pulse says keep or drop
					rx_data_nxt = mac_rx_data;
					rx_data_valid_nxt = 1'b1;
					rx_crc_nxt = crc32_byte(rx_crc_r, mac_rx_data);
					rx_left_nxt = 11'(rx_left_r - 11'h001);
					rx_idx_nxt = 11'h000;
					if (mac_rx_last) begin
						rx_err_nxt = 1'b1;
						rx_state_nxt = RX_HDR;
					end else if (rx_left_r == 11'h001) begin
						rx_state_nxt = RX_TAIL;
					end
				end
				RX_TAIL: begin
					rx_word_nxt = rx_last_word;
					if (rx_idx_r == WORD_LAST_IDX || mac_rx_last) begin
						rx_idx_nxt = 11'h000;
						rx_state_nxt = mac_rx_last ? RX_HDR : RX_SKIP;
						if (mac_rx_last && rx_idx_r == WORD_LAST_IDX && rx_last_word == rx_crc_r) begin
							rx_ok_nxt = 1'b1;
						end else begin
							rx_err_nxt = 1'b1;
						end
					end
				end
				RX_SKIP: begin
					rx_idx_nxt = 11'h000;
					if (mac_rx_last) begin
						rx_state_nxt = RX_HDR;
					end
				end
				default: rx_state_nxt = RX_HDR;
			endcase
		end
	end

	// ************************************************************
	// receive registers
	// ************************************************************
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			rx_state_r <= RX_HDR;
			rx_idx_r <= 11'h000;
			rx_left_r <= 11'h000;
			rx_len_r <= 11'h000;
			rx_hdr_r <= 32'h00000000;
			rx_word_r <= 32'h00000000;
			rx_crc_r <= CRC32_INIT;
			rx_info_r <= '0;
			rx_data_r <= 8'h00;
			rx_data_valid_r <= 1'b0;
			rx_ok_r <= 1'b0;
			rx_err_r <= 1'b0;
			rx_hop_err_r <= 1'b0;
		end else begin
			rx_state_r <= rx_state_nxt;
			rx_idx_r <= rx_idx_nxt;
			rx_left_r <= rx_left_nxt;
			rx_len_r <= rx_len_nxt;
			rx_hdr_r <= rx_hdr_nxt;
			rx_word_r <= rx_word_nxt;
			rx_crc_r <= rx_crc_nxt;
			rx_info_r <= rx_info_nxt;
			rx_data_r <= rx_data_nxt;
			rx_data_valid_r <= rx_data_valid_nxt;
			rx_ok_r <= rx_ok_nxt;
			rx_err_r <= rx_err_nxt;
			rx_hop_err_r <= rx_hop_err_nxt;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign tx_req_ready = tx_req_ready_r;
	assign tx_req_err = tx_req_err_r;
	assign mac_tx_data = mac_tx_data_r;
	assign mac_tx_valid = mac_tx_valid_r;
	assign mac_tx_last = mac_tx_last_r;
	assign rx_info = rx_info_r;
	assign rx_data = rx_data_r;
	assign rx_data_valid = rx_data_valid_r;
	assign rx_frame_ok = rx_ok_r;
	assign rx_frame_err = rx_err_r;
	assign rx_hop_err = rx_hop_err_r;
endmodule

// ---- testbench/framer_sva.sv ----
// port checker for the framer: request screening, tx stream, rx pulses
// assumes the single sys_clk domain with sys_rst active high
`timescale 1ns/1ps
module framer_sva
	import llc_xhdr_pkg::*;
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire tx_req_s tx_req,
	input wire logic tx_req_valid,
	input wire logic tx_req_ready,
	input wire logic tx_req_err,
	input wire logic [7:0] mac_tx_data,
	input wire logic mac_tx_valid,
	input wire logic mac_tx_ready,
	input wire logic mac_rx_valid,
	input wire logic mac_rx_last,
	input wire logic rx_frame_ok,
	input wire logic rx_hop_err
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	// request taken at this edge
	sequence take_s;
		tx_req_valid && tx_req_ready;
	endsequence
	sequence bad_len_s;
		take_s ##0 (tx_req.len < LEN_MIN || tx_req.len > LEN_MAX);
	endsequence
	sequence good_ui_s;
		take_s ##0 (!tx_req.is_test && tx_req.len >= LEN_MIN && tx_req.len <= LEN_MAX);
	endsequence
	a_len_refused: assert property (bad_len_s |=> tx_req_err)
		else $error("bad length not refused");
	a_len_taken: assert property (good_ui_s |=> !tx_req_err)
		else $error("good length refused");
	a_hop_refused: assert property (take_s ##0 (tx_req.is_test && tx_req.hop > HOP_MAX) |=> tx_req_err)
		else $error("hop above limit not refused");
	a_len_first: assert property (good_ui_s ##0 !mac_tx_valid |->
		##2 mac_tx_valid && mac_tx_data == {5'h00, $past(tx_req.len[10:8], 2)})
		else $error("first byte not length high");
	a_tx_holds: assert property (mac_tx_valid && !mac_tx_ready |=> mac_tx_valid && $stable(mac_tx_data))
		else $error("tx byte dropped while stalled");
	a_err_pulse: assert property (tx_req_err |=> !tx_req_err)
		else $error("refusal pulse too long");
	a_ok_after_last: assert property (rx_frame_ok |-> $past(mac_rx_valid && mac_rx_last))
		else $error("frame ok without last byte");
	a_hop_cause: assert property (rx_hop_err |-> $past(mac_rx_valid) && !rx_frame_ok)
		else $error("hop error without byte");
endmodule
bind llc_extended_header_framer framer_sva chk (.sys_clk, .sys_rst, .tx_req, .tx_req_valid,
	.tx_req_ready, .tx_req_err, .mac_tx_data, .mac_tx_valid, .mac_tx_ready, .mac_rx_valid,
	.mac_rx_last, .rx_frame_ok, .rx_hop_err);

// ---- testbench/mac_model.sv ----
// mac stand-in: tx byte sink that logs bytes, optionally stalling
// assumes the framer's registered valid/ready tx stream
`timescale 1ns/1ps
module mac_model (
	input wire logic sys_clk,
	input wire logic [7:0] mac_tx_data,
	input wire logic mac_tx_valid,
	input wire logic mac_tx_last,
	output logic mac_tx_ready
);
	logic [7:0] got [$]; // accepted bytes
	int n_last = 0; // frames ended
	logic slow = 0; // stall every other cycle
	initial mac_tx_ready = 1'b0;
	// accept on valid and ready, like a real mac
	always @(posedge sys_clk) begin
		if (mac_tx_valid && mac_tx_ready) begin
			got.push_back(mac_tx_data);
			n_last += mac_tx_last;
		end
		mac_tx_ready <= #1 slow ? !mac_tx_ready : 1'b1;
	end
endmodule

// ---- testbench/tb_llc_extended_header_framer.sv ----
// self-checking bench for the framer with a stalling mac stand-in
// assumes the 16384-cycle sequence sweep after reset
`timescale 1ns/1ps
module tb_llc_extended_header_framer;
	import llc_xhdr_pkg::*;
	logic sys_clk = 0, sys_rst = 1, tx_req_valid = 0, pay_valid = 0;
	logic mac_rx_valid = 0, mac_rx_last = 0, tx_req_ready, tx_req_err, pay_ready;
	logic mac_tx_valid, mac_tx_last, mac_tx_ready, rx_hop_err, rx_frame_ok, rx_frame_err;
	logic rx_data_valid;
	logic [7:0] pay_data = 0, mac_rx_data = 0, mac_tx_data;
	logic [19:0] usec_in_sec = 20'h12345, sec_of_day = 20'h0abcd;
	tx_req_s tx_req = '0;
	rx_info_s rx_info;
	int fail_count = 0, checks = 0, cyc = 0, hops = 0, oks = 0, errs = 0, nd = 0;
	llc_extended_header_framer dut (.sys_clk, .sys_rst, .tx_req, .tx_req_valid, .tx_req_ready,
		.tx_req_err, .pay_data, .pay_valid, .pay_ready, .usec_in_sec, .sec_of_day, .mac_tx_data,
		.mac_tx_valid, .mac_tx_last, .mac_tx_ready, .mac_rx_data, .mac_rx_valid, .mac_rx_last,
		.rx_info, .rx_data(), .rx_data_valid, .rx_frame_ok, .rx_frame_err, .rx_hop_err);
	mac_model mac (.sys_clk, .mac_tx_data, .mac_tx_valid, .mac_tx_last, .mac_tx_ready);
	initial forever #4 sys_clk = ~sys_clk;
	// cycle ceiling, hop error count, counting payload source
	always @(posedge sys_clk) begin
		cyc++;
		hops += rx_hop_err;
		oks += rx_frame_ok;
		errs += rx_frame_err;
		nd += rx_data_valid;
		if (pay_valid && pay_ready) pay_data <= #1 pay_data + 8'h01;
		if (cyc == 40000) begin
			fail_count++;
			report_and_stop;
		end
	end
	task automatic report_and_stop;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %s exp %h got %h", what, exp, got);
		end
	endtask
	// hold the request until an edge sees ready
	task automatic req(input logic t, input logic [7:0] d, s, h, input logic [10:0] l);
		tx_req = '{t, d, s, h, l};
		tx_req_valid = 1;
		while (tx_req_ready !== 1'b1) begin
			@(posedge sys_clk);
			#1;
		end
		@(posedge sys_clk);
		#1 tx_req_valid = 0;
	endtask
	task automatic ui(input logic [7:0] d, s, sq, input int n, input logic [19:0] st);
		mac.got.delete();
		req(0, d, s, 0, 11'd46);
		while (mac.n_last < n) begin
			@(posedge sys_clk);
			#1;
		end
		chk("size", 48, mac.got.size());
		chk("len", 16'h002e, {mac.got[0], mac.got[1]});
		chk("saps", {d & 8'hfe, s & 8'hfe}, {mac.got[2], mac.got[3]});
		chk("ctrl", 8'h03, mac.got[4]);
		chk("seq", sq, mac.got[5]);
		chk("stamp", st, {mac.got[6], mac.got[7], mac.got[8][7:4]});
	endtask
	// zero-body test pdu from the wire, or the captured tx frame when lb; last on byte 47
	task automatic rx(input logic lb, input logic [7:0] h);
		for (int i = 0; i < 48; i++) begin
			@(posedge sys_clk);
			#1 mac_rx_valid = 1;
			mac_rx_last = (i == 47);
			mac_rx_data = lb ? mac.got[i] : i == 1 ? 8'h2e : i == 2 || i == 3 ? 8'h01
				: i == 4 ? 8'he3 : i == 5 ? h : 8'h00;
		end
		@(posedge sys_clk);
		#1 mac_rx_valid = 0;
		mac_rx_last = 0;
		// one more edge so the end pulses are counted
		@(posedge sys_clk);
		#1;
	endtask
	initial begin
		repeat (5) @(posedge sys_clk);
		#1 sys_rst = 0;
		pay_valid = 1;
		ui(8'h13, 8'h22, 8'h00, 1, sec_of_day);
		rx(1, 8'h00);
		chk("rx ok", 1, oks);
		chk("rx bytes", 34, nd);
		mac.got[20] ^= 8'h01;
		rx(1, 8'h00);
		chk("rx crc err", 1, errs);
		mac.slow = 1;
		ui(8'h13, 8'h22, 8'h01, 2, usec_in_sec);
		ui(8'h24, 8'h22, 8'h00, 3, sec_of_day);
		mac.slow = 0;
		req(0, 8'h12, 8'h22, 0, 11'd45);
		chk("len refused", 1, tx_req_err);
		@(posedge sys_clk);
		#1 req(1, 8'h01, 8'h01, 8'h40, 11'd46);
		chk("hop refused", 1, tx_req_err);
		rx(0, 8'h02);
		chk("hop err", 1, hops);
		chk("fwd hop", 8'h01, rx_info.fwd_hop);
		mac.got.delete();
		rx(0, 8'h00);
		while (mac.n_last < 4) begin
			@(posedge sys_clk);
			#1;
		end
		chk("echo", 32'h0101e3c0, {mac.got[2], mac.got[3], mac.got[4], mac.got[5]});
		report_and_stop;
	end
endmodule
